// [rtl/evtrc_top.sv]
// Event-condition channels, sequencer and internal trace recorder
// Behaviour
// - Sequential break needs channel 3, 2, 1 order
// - Setting a combination disables its channels
// - Delay-slot PC match reported before branch target
// - Power-on reset blocks all coincident matches
// - Settings change suspends CPU at most 102
// - No matches while settings are updated
// - Trace type selects recorded bus categories
// - Internal bus records filtered by bus master
// - Disabled categories never reach trace memory
// - Trace halt stops recording, program continues
// - Conditional mode stores only matching data accesses
// - Window and conditional filter are ANDed
// - Records carry 48-bit bus clock timestamp
// - Stamp at completion; branches at next cycle
// - Window starts on fetch, overrun fetch suspends
// - Reset point discards partial sequence progress
// - Count repeats sequence before the action
module evtrc_top (
   input wire logic REF_CLK,
   input wire logic SRST,
   input wire logic CFG_WE,
   input wire logic [2:0] CFG_CH,
   input wire logic [31:0] CFG_ADDR,
   input wire logic [1:0] CFG_KIND,
   input wire logic CH_EN_WE,
   input wire logic [2:0] CH_EN_SEL,
   input wire logic COMBO_WE,
   input wire logic [1:0] COMBO_SEQ,
   input wire logic COMBO_RP_EN,
   input wire logic [7:0] COMBO_COUNT,
   input wire logic COMBO_WINDOW_TRACE_SPAN_EN,
   input wire logic [1:0] TRC_TYPE,
   input wire logic [8:0] TRC_ACQ_EN,
   input wire logic TRC_COND_EN,
   input wire logic TRC_HALT_EN,
   input wire logic [2:0] TRC_HALT_CH,
   input wire logic TRC_RESTART,
   input wire logic EXEC_VALID,
   input wire logic [31:0] EXEC_PC,
   input wire logic BUS_VALID,
   input wire logic [31:0] BUS_ADDR,
   input wire logic [1:0] BUS_KIND,
   input wire logic BUS_PCREL,
   input wire logic BUS_IBUS,
   input wire logic [1:0] BUS_MASTER,
   input wire logic BR_VALID,
   input wire logic [31:0] BR_ADDR,
   input wire logic FETCH_OVERRUN,
   input wire logic POR_EVT,
   input wire logic [7:0] TRC_RD_ADDR,
   output logic BRK_REQ,
   output logic CPU_HOLD,
   output logic TRC_STOPPED,
   output logic WIN_ACTIVE,
   output logic [5:0] CH_EN_STATE,
   output logic [7:0] TRC_WR_PTR,
   output logic [evtrc_pkg::RECW-1:0] TRC_RD_DATA,
   output logic [47:0] TS_NOW
);
   logic [31:0] ch_addr_reg [evtrc_pkg::NCH];
   logic [31:0] ch_addr_next [evtrc_pkg::NCH];
   logic [1:0] ch_kind_reg [evtrc_pkg::NCH];
   logic [1:0] ch_kind_next [evtrc_pkg::NCH];
   logic [5:0] ch_en_reg, ch_en_next;
   logic [1:0] seq_mode_reg, seq_mode_next;
   logic rp_en_reg, rp_en_next;
   logic window_trace_span_en_reg, window_trace_span_en_next;
   logic [7:0] count_cfg_reg, count_cfg_next;
   logic [7:0] seq_cnt_reg, seq_cnt_next;
   evtrc_pkg::evtrc_seq_e seq_reg, seq_next;
   logic [6:0] hold_cnt_reg, hold_cnt_next;
   logic hold_reg, hold_next;
   logic [47:0] ts_reg, ts_next;
   logic brk_reg, brk_next;
   logic stop_reg, stop_next;
   logic win_reg, win_next;
   logic win_pend_reg, win_pend_next;
   logic br_pend_reg, br_pend_next;
   logic br_ok_reg, br_ok_next;
   logic [31:0] br_addr_reg, br_addr_next;
   logic skid_v_reg, skid_v_next;
   logic [evtrc_pkg::RECW-1:0] skid_reg, skid_next;
   logic [7:0] wptr_reg, wptr_next;
   logic [5:0] hit;
   logic seq_fire;
   logic mem_we;
   logic [evtrc_pkg::RECW-1:0] mem_wdata;
   logic [evtrc_pkg::RECW-1:0] data_rec;
   logic data_ok;
   logic [2:0] data_kind;
   logic [7:0] count_goal;

   // Raw comparator of one channel against the current cycle's events
   function automatic logic ch_raw(input logic [1:0] kind, input logic [31:0] addr);
      logic r;
      r = 1'b0;
      unique case (kind)
         evtrc_pkg::KIND_PC_AFTER: r = EXEC_VALID && (EXEC_PC == addr);
         evtrc_pkg::KIND_FETCH: r = BUS_VALID && (BUS_KIND == evtrc_pkg::BUS_FETCH)
            && (BUS_ADDR == addr);
         evtrc_pkg::KIND_DATA: r = BUS_VALID && (BUS_KIND != evtrc_pkg::BUS_FETCH)
            && (BUS_ADDR == addr);
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   always_comb begin
      for (int i = 0; i < evtrc_pkg::NCH; i++) begin
         hit[i] = ch_en_reg[i] && (hold_cnt_reg == '0) && !POR_EVT
            && ch_raw(ch_kind_reg[i], ch_addr_reg[i]);
      end
   end

   always_comb begin
      ch_addr_next = ch_addr_reg;
      ch_kind_next = ch_kind_reg;
      ch_en_next = ch_en_reg;
      seq_mode_next = seq_mode_reg;
      rp_en_next = rp_en_reg;
      window_trace_span_en_next = window_trace_span_en_reg;
      count_cfg_next = count_cfg_reg;
      seq_cnt_next = seq_cnt_reg;
      seq_next = seq_reg;
      hold_cnt_next = hold_cnt_reg;
      ts_next = ts_reg + evtrc_pkg::TS_ONE;
      brk_next = 1'b0;
      stop_next = stop_reg;
      win_next = win_reg;
      win_pend_next = win_pend_reg;
      br_pend_next = br_pend_reg;
      br_ok_next = br_ok_reg;
      br_addr_next = br_addr_reg;
      skid_v_next = 1'b0;
      skid_next = skid_reg;
      wptr_next = wptr_reg;
      seq_fire = 1'b0;
      mem_we = 1'b0;
      mem_wdata = skid_reg;
      count_goal = (count_cfg_reg == '0) ? evtrc_pkg::CNT_ONE : count_cfg_reg;
      if (hold_cnt_reg != '0) begin
         hold_cnt_next = hold_cnt_reg - 7'h1;
      end
      // Ordered chain 3-2-1, reset point wins over any advance but not over a completing channel 1 hit
      unique case (seq_reg)
         evtrc_pkg::SQ_IDLE: if (hit[evtrc_pkg::CH3]) seq_next = evtrc_pkg::SQ_GOT3;
         evtrc_pkg::SQ_GOT3: if (hit[evtrc_pkg::CH2]) seq_next = evtrc_pkg::SQ_GOT2;
         evtrc_pkg::SQ_GOT2: begin
            if (hit[evtrc_pkg::CH1]) begin
               seq_next = evtrc_pkg::SQ_IDLE;
               seq_cnt_next = seq_cnt_reg + evtrc_pkg::CNT_ONE;
               if (seq_cnt_next >= count_goal) begin
                  seq_fire = (seq_mode_reg != evtrc_pkg::SEQ_NONE);
                  seq_cnt_next = '0;
               end
            end
         end
         default: seq_next = evtrc_pkg::SQ_IDLE;
      endcase
      if (rp_en_reg && hit[evtrc_pkg::CHRP]) begin
         seq_next = evtrc_pkg::SQ_IDLE;
      end
      if (seq_fire && seq_mode_reg == evtrc_pkg::SEQ_BRK) brk_next = 1'b1;
      // A stop request wins over a same-cycle restart
      if (TRC_RESTART) stop_next = 1'b0;
      if (seq_fire && seq_mode_reg == evtrc_pkg::SEQ_TSTOP) stop_next = 1'b1;
      if (TRC_HALT_EN && hit[TRC_HALT_CH]) stop_next = 1'b1;
      // Window span: start on channel 5 match, end on channel 4 or an overrun while pending; a fresh start wins
      if (window_trace_span_en_reg) begin
         if (win_pend_reg && FETCH_OVERRUN) begin
            win_next = 1'b0;
            win_pend_next = 1'b0;
         end else if (win_pend_reg && EXEC_VALID && EXEC_PC == ch_addr_reg[evtrc_pkg::CH5]) begin
            win_pend_next = 1'b0;
         end
         if (hit[evtrc_pkg::CH5]) begin
            win_next = 1'b1;
            win_pend_next = 1'b1;
         end else if (hit[evtrc_pkg::CH4]) begin
            win_next = 1'b0;
         end
      end
      // Categories and master filter
      data_kind = (BUS_KIND == evtrc_pkg::BUS_FETCH) ? evtrc_pkg::REC_FETCH :
         BUS_PCREL ? evtrc_pkg::REC_PCREL :
         (BUS_KIND == evtrc_pkg::BUS_WR) ? evtrc_pkg::REC_WRITE : evtrc_pkg::REC_READ;
      data_ok = 1'b0;
      if (!BUS_IBUS && TRC_TYPE != evtrc_pkg::TT_IBUS) begin
         data_ok = BUS_PCREL ? TRC_ACQ_EN[evtrc_pkg::ACQ_PCREL] && !BUS_KIND[1] :
            TRC_ACQ_EN[evtrc_pkg::ACQ_DATA] && (BUS_KIND != evtrc_pkg::BUS_FETCH);
      end else if (BUS_IBUS && TRC_TYPE != evtrc_pkg::TT_MBUS) begin
         data_ok = (BUS_KIND == evtrc_pkg::BUS_FETCH) ? TRC_ACQ_EN[evtrc_pkg::ACQ_FETCH] :
            TRC_ACQ_EN[evtrc_pkg::ACQ_DATA];
         data_ok = data_ok && ((BUS_MASTER == evtrc_pkg::MST_CPU && TRC_ACQ_EN[evtrc_pkg::ACQ_CPU])
            || (BUS_MASTER == evtrc_pkg::MST_DMA && TRC_ACQ_EN[evtrc_pkg::ACQ_DMA])
            || (BUS_MASTER == evtrc_pkg::MST_ADMA && TRC_ACQ_EN[evtrc_pkg::ACQ_ADMA]));
      end
      if (BUS_KIND == evtrc_pkg::BUS_RD && !TRC_ACQ_EN[evtrc_pkg::ACQ_READ]) data_ok = 1'b0;
      if (BUS_KIND == evtrc_pkg::BUS_WR && !TRC_ACQ_EN[evtrc_pkg::ACQ_WRITE]) data_ok = 1'b0;
      if (TRC_COND_EN && BUS_KIND != evtrc_pkg::BUS_FETCH && !hit[evtrc_pkg::CH1]) begin
         data_ok = 1'b0;
      end
      if (window_trace_span_en_reg && !win_reg) data_ok = 1'b0;
      data_ok = data_ok && BUS_VALID && !stop_reg;
      data_rec = {ts_reg, data_kind, BUS_MASTER, BUS_ADDR};
      // Branch waits for the completion of the next bus cycle
      if (BR_VALID) begin
         br_pend_next = 1'b1;
         br_addr_next = BR_ADDR;
         br_ok_next = TRC_ACQ_EN[evtrc_pkg::ACQ_BRANCH] && (TRC_TYPE != evtrc_pkg::TT_IBUS)
            && (!window_trace_span_en_reg || win_reg);
      end
      if (BUS_VALID && br_pend_reg) begin
         br_pend_next = BR_VALID;
         mem_we = br_ok_reg && !stop_reg;
         mem_wdata = {ts_reg, evtrc_pkg::REC_BRANCH, evtrc_pkg::MST_CPU, br_addr_reg};
         skid_v_next = data_ok;
         skid_next = data_rec;
      end else if (skid_v_reg) begin
         mem_we = !stop_reg;
         skid_v_next = data_ok;
         skid_next = data_rec;
      end else if (data_ok) begin
         mem_we = 1'b1;
         mem_wdata = data_rec;
      end
      if (mem_we) wptr_next = wptr_reg + evtrc_pkg::PTR_ONE;
      // Host-side configuration
      if (CH_EN_WE && CH_EN_SEL < 3'(evtrc_pkg::NCH)) ch_en_next[CH_EN_SEL] = 1'b1;
      if (CFG_WE && CFG_CH < 3'(evtrc_pkg::NCH)) begin
         ch_addr_next[CFG_CH] = CFG_ADDR;
         ch_kind_next[CFG_CH] = CFG_KIND;
         hold_cnt_next = evtrc_pkg::UPD_HOLD_CYC;
      end
      if (COMBO_WE) begin
         seq_mode_next = COMBO_SEQ;
         rp_en_next = COMBO_RP_EN;
         window_trace_span_en_next = COMBO_WINDOW_TRACE_SPAN_EN;
         count_cfg_next = COMBO_COUNT;
         seq_cnt_next = '0;
         seq_next = evtrc_pkg::SQ_IDLE;
         win_next = 1'b0;
         win_pend_next = 1'b0;
         hold_cnt_next = evtrc_pkg::UPD_HOLD_CYC;
         if (COMBO_SEQ != evtrc_pkg::SEQ_NONE) begin
            ch_en_next[evtrc_pkg::CH1] = 1'b0;
            ch_en_next[evtrc_pkg::CH2] = 1'b0;
            ch_en_next[evtrc_pkg::CH3] = 1'b0;
            ch_en_next[evtrc_pkg::CHRP] = 1'b0;
         end
         if (COMBO_WINDOW_TRACE_SPAN_EN) begin
            ch_en_next[evtrc_pkg::CH4] = 1'b0;
            ch_en_next[evtrc_pkg::CH5] = 1'b0;
         end
      end
      hold_next = (hold_cnt_next != '0);
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         for (int i = 0; i < evtrc_pkg::NCH; i++) begin
            ch_addr_reg[i] <= '0;
            ch_kind_reg[i] <= evtrc_pkg::KIND_PC_AFTER;
         end
         ch_en_reg <= '0;
         seq_mode_reg <= evtrc_pkg::SEQ_NONE;
         rp_en_reg <= 1'b0;
         window_trace_span_en_reg <= 1'b0;
         count_cfg_reg <= '0;
         seq_cnt_reg <= '0;
         seq_reg <= evtrc_pkg::SQ_IDLE;
         hold_cnt_reg <= '0;
         hold_reg <= 1'b0;
         ts_reg <= '0;
         brk_reg <= 1'b0;
         stop_reg <= 1'b0;
         win_reg <= 1'b0;
         win_pend_reg <= 1'b0;
         br_pend_reg <= 1'b0;
         br_ok_reg <= 1'b0;
         br_addr_reg <= '0;
         skid_v_reg <= 1'b0;
         skid_reg <= '0;
         wptr_reg <= '0;
      end else begin
         ch_addr_reg <= ch_addr_next;
         ch_kind_reg <= ch_kind_next;
         ch_en_reg <= ch_en_next;
         seq_mode_reg <= seq_mode_next;
         rp_en_reg <= rp_en_next;
         window_trace_span_en_reg <= window_trace_span_en_next;
         count_cfg_reg <= count_cfg_next;
         seq_cnt_reg <= seq_cnt_next;
         seq_reg <= seq_next;
         hold_cnt_reg <= hold_cnt_next;
         hold_reg <= hold_next;
         ts_reg <= ts_next;
         brk_reg <= brk_next;
         stop_reg <= stop_next;
         win_reg <= win_next;
         win_pend_reg <= win_pend_next;
         br_pend_reg <= br_pend_next;
         br_ok_reg <= br_ok_next;
         br_addr_reg <= br_addr_next;
         skid_v_reg <= skid_v_next;
         skid_reg <= skid_next;
         wptr_reg <= wptr_next;
      end
   end

   evtrc_mem u_mem (
      .clk(REF_CLK),
      .wr_en(mem_we),
      .wr_addr(wptr_reg),
      .wr_data(mem_wdata),
      .rd_addr(TRC_RD_ADDR),
      .rd_data(TRC_RD_DATA)
   );

   assign BRK_REQ = brk_reg;
   assign CPU_HOLD = hold_reg;
   assign TRC_STOPPED = stop_reg;
   assign WIN_ACTIVE = win_reg;
   assign CH_EN_STATE = ch_en_reg;
   assign TRC_WR_PTR = wptr_reg;
   assign TS_NOW = ts_reg;

   chk_seq_order: assert property (@(posedge REF_CLK) disable iff (SRST)
      BRK_REQ |-> $past(seq_reg) == evtrc_pkg::SQ_GOT2 && $past(hit[evtrc_pkg::CH1]))
      else $error("Break without ordered chain");
   chk_combo_disable: assert property (@(posedge REF_CLK) disable iff (SRST)
      COMBO_WE && COMBO_SEQ != evtrc_pkg::SEQ_NONE && !CH_EN_WE |=> ch_en_reg[2:0] == 3'h0)
      else $error("Combination left channels enabled");
   chk_break_prompt: assert property (@(posedge REF_CLK) disable iff (SRST)
      seq_fire && seq_mode_reg == evtrc_pkg::SEQ_BRK |=> BRK_REQ ##1 !BRK_REQ)
      else $error("Break not raised next cycle");
   chk_por_block: assert property (@(posedge REF_CLK) disable iff (SRST)
      POR_EVT |-> hit == 6'h0)
      else $error("Match during power-on reset");
   chk_hold_bound: assert property (@(posedge REF_CLK) disable iff (SRST)
      $rose(CPU_HOLD) |-> ##[1:102] !CPU_HOLD)
      else $error("Suspension too long");
   chk_upd_nomatch: assert property (@(posedge REF_CLK) disable iff (SRST)
      CPU_HOLD |-> hit == 6'h0)
      else $error("Match during settings update");
   chk_ts_step: assert property (@(posedge REF_CLK) disable iff (SRST)
      !$past(SRST) |-> TS_NOW == $past(TS_NOW) + evtrc_pkg::TS_ONE)
      else $error("Timestamp did not advance");
   chk_halt_stop: assert property (@(posedge REF_CLK) disable iff (SRST)
      TRC_STOPPED && !TRC_RESTART |=> $stable(TRC_WR_PTR))
      else $error("Recording after trace halt");
   chk_rp_discard: assert property (@(posedge REF_CLK) disable iff (SRST)
      rp_en_reg && hit[evtrc_pkg::CHRP] && !COMBO_WE |=> seq_reg == evtrc_pkg::SQ_IDLE)
      else $error("Reset point kept progress");
endmodule

// [pkg/evtrc_pkg.sv]
// Shared constants for the event-condition and internal trace block
package evtrc_pkg;
   localparam int NCH = 6;
   localparam int CHW = 3;
   localparam int AW = 32;
   localparam int TSW = 48;
   localparam int MAW = 8;
   localparam int KW = 3;
   localparam int MSW = 2;
   localparam int RECW = TSW + KW + MSW + AW;
   localparam int ACQW = 9;
   localparam int CNTW = 8;
   // Channel slots
   localparam logic [CHW-1:0] CH1 = 3'h0;
   localparam logic [CHW-1:0] CH2 = 3'h1;
   localparam logic [CHW-1:0] CH3 = 3'h2;
   localparam logic [CHW-1:0] CH4 = 3'h3;
   localparam logic [CHW-1:0] CH5 = 3'h4;
   localparam logic [CHW-1:0] CHRP = 3'h5;
   // Channel match kinds
   localparam logic [1:0] KIND_PC_AFTER = 2'h0;
   localparam logic [1:0] KIND_FETCH = 2'h1;
   localparam logic [1:0] KIND_DATA = 2'h2;
   // Bus cycle kinds
   localparam logic [1:0] BUS_RD = 2'h0;
   localparam logic [1:0] BUS_WR = 2'h1;
   localparam logic [1:0] BUS_FETCH = 2'h2;
   // Bus masters on the internal bus
   localparam logic [MSW-1:0] MST_CPU = 2'h0;
   localparam logic [MSW-1:0] MST_DMA = 2'h1;
   localparam logic [MSW-1:0] MST_ADMA = 2'h2;
   // Sequential combination modes
   localparam logic [1:0] SEQ_NONE = 2'h0;
   localparam logic [1:0] SEQ_BRK = 2'h1;
   localparam logic [1:0] SEQ_TSTOP = 2'h2;
   // Trace types
   localparam logic [1:0] TT_MBUS = 2'h0;
   localparam logic [1:0] TT_IBUS = 2'h1;
   localparam logic [1:0] TT_BOTH = 2'h2;
   // Acquisition enable bits
   localparam int ACQ_READ = 0;
   localparam int ACQ_WRITE = 1;
   localparam int ACQ_PCREL = 2;
   localparam int ACQ_BRANCH = 3;
   localparam int ACQ_DATA = 4;
   localparam int ACQ_FETCH = 5;
   localparam int ACQ_CPU = 6;
   localparam int ACQ_DMA = 7;
   localparam int ACQ_ADMA = 8;
   // Record kinds stored in trace memory
   localparam logic [KW-1:0] REC_READ = 3'h0;
   localparam logic [KW-1:0] REC_WRITE = 3'h1;
   localparam logic [KW-1:0] REC_PCREL = 3'h2;
   localparam logic [KW-1:0] REC_BRANCH = 3'h3;
   localparam logic [KW-1:0] REC_FETCH = 3'h4;
   // Settings-update suspension, in bus clock cycles
   localparam int UPD_MAX_CYC = 102;
   localparam logic [6:0] UPD_HOLD_CYC = 7'h10;
   localparam logic [TSW-1:0] TS_ONE = 48'h1;
   localparam logic [CNTW-1:0] CNT_ONE = 8'h1;
   localparam logic [MAW-1:0] PTR_ONE = 8'h1;
   typedef enum logic [2:0] {
      SQ_IDLE = 3'b001,
      SQ_GOT3 = 3'b010,
      SQ_GOT2 = 3'b100
   } evtrc_seq_e;
endpackage

// [rtl/evtrc_mem.sv]
// Trace record memory with registered read data
module evtrc_mem (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [evtrc_pkg::MAW-1:0] wr_addr,
   input wire logic [evtrc_pkg::RECW-1:0] wr_data,
   input wire logic [evtrc_pkg::MAW-1:0] rd_addr,
   output logic [evtrc_pkg::RECW-1:0] rd_data
);
   logic [evtrc_pkg::RECW-1:0] mem [0:(1<<evtrc_pkg::MAW)-1];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

// [tb/evtrc_emu.sv]
// Emulator-side model that writes channel and combination settings
module evtrc_emu (
   input wire logic clk,
   output logic cfg_we,
   output logic [2:0] cfg_ch,
   output logic [31:0] cfg_addr,
   output logic [1:0] cfg_kind,
   output logic ch_en_we,
   output logic [2:0] ch_en_sel,
   output logic combo_we,
   output logic [1:0] combo_seq,
   output logic combo_rp_en,
   output logic [7:0] combo_count,
   output logic combo_window_trace_span_en
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {cfg_we, cfg_ch, cfg_addr, cfg_kind, ch_en_we, ch_en_sel} = '0;
      {combo_we, combo_seq, combo_rp_en, combo_count, combo_window_trace_span_en} = '0;
   end
   // Addresses are upper halves of plain code points, never sleep or divide slots
   task automatic cfg(input logic [2:0] ch, input logic [31:0] a, input logic [1:0] k);
      @(negedge clk);
      cfg_we = 1'h1;
      cfg_ch = ch;
      cfg_addr = a;
      cfg_kind = k;
      @(negedge clk);
      cfg_we = 1'h0;
   endtask
   task automatic en(input logic [2:0] ch);
      @(negedge clk);
      ch_en_we = 1'h1;
      ch_en_sel = ch;
      @(negedge clk);
      ch_en_we = 1'h0;
   endtask
   // Chains are PC-only, so no data hit ever precedes a PC step
   task automatic combo(input logic [1:0] s, input logic rp, input logic [7:0] n,
                        input logic p = 1'h0);
      @(negedge clk);
      combo_we = 1'h1;
      combo_seq = s;
      combo_rp_en = rp;
      combo_count = n;
      combo_window_trace_span_en = p;
      @(negedge clk);
      combo_we = 1'h0;
   endtask
endmodule

// [tb/evtrc_top_tb.sv]
// Self-checking bench for the event-condition and trace block
module evtrc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0;
   logic srst = 1'h1;
   logic [1:0] ttype = '0;
   logic [8:0] acq = '0;
   logic cond = 1'h0;
   logic halt = 1'h0;
   logic restart = 1'h0;
   logic ev = 1'h0;
   logic [31:0] pc = '0;
   logic bv = 1'h0;
   logic [31:0] ba = '0;
   logic [1:0] bk = '0;
   logic ibus = 1'h0;
   logic [1:0] mst = '0;
   logic por = 1'h0;
   logic [7:0] rda = '0;
   logic [7:0] wp = '0;
   logic br = 1'h0;
   logic [31:0] bra = '0;
   logic ovr = 1'h0;
   logic win;
   logic cfg_we, ch_en_we, combo_we, combo_rp, combo_window_trace_span, brk, hold, stopped;
   logic [2:0] cfg_ch, en_sel;
   logic [31:0] cfg_addr;
   logic [1:0] cfg_kind, combo_seq;
   logic [7:0] combo_cnt, wptr;
   logic [5:0] chen;
   logic [evtrc_pkg::RECW-1:0] rdat;
   logic [47:0] tsn;
   int n_mismatch = 0;
   int checked = 0;
   int nbrk = 0;
   always #12.5 clk = ~clk;
   always @(posedge clk) if (brk === 1'h1) nbrk++;
   evtrc_emu i_emu (.clk(clk), .cfg_we(cfg_we), .cfg_ch(cfg_ch), .cfg_addr(cfg_addr),
      .cfg_kind(cfg_kind), .ch_en_we(ch_en_we), .ch_en_sel(en_sel), .combo_we(combo_we),
      .combo_seq(combo_seq), .combo_rp_en(combo_rp), .combo_count(combo_cnt),
      .combo_window_trace_span_en(combo_window_trace_span));
   evtrc_top i_dut (.REF_CLK(clk), .SRST(srst), .CFG_WE(cfg_we), .CFG_CH(cfg_ch),
      .CFG_ADDR(cfg_addr), .CFG_KIND(cfg_kind), .CH_EN_WE(ch_en_we), .CH_EN_SEL(en_sel),
      .COMBO_WE(combo_we), .COMBO_SEQ(combo_seq), .COMBO_RP_EN(combo_rp),
      .COMBO_COUNT(combo_cnt), .COMBO_WINDOW_TRACE_SPAN_EN(combo_window_trace_span), .TRC_TYPE(ttype), .TRC_ACQ_EN(acq),
      .TRC_COND_EN(cond), .TRC_HALT_EN(halt), .TRC_HALT_CH(evtrc_pkg::CH1),
      .TRC_RESTART(restart), .EXEC_VALID(ev), .EXEC_PC(pc), .BUS_VALID(bv), .BUS_ADDR(ba),
      .BUS_KIND(bk), .BUS_PCREL(1'h0), .BUS_IBUS(ibus), .BUS_MASTER(mst), .BR_VALID(br),
      .BR_ADDR(bra), .FETCH_OVERRUN(ovr), .POR_EVT(por), .TRC_RD_ADDR(rda), .BRK_REQ(brk),
      .CPU_HOLD(hold), .TRC_STOPPED(stopped), .WIN_ACTIVE(win), .CH_EN_STATE(chen),
      .TRC_WR_PTR(wptr), .TRC_RD_DATA(rdat), .TS_NOW(tsn));
   task automatic chk(input logic [84:0] got, input logic [84:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // A filler instruction and an idle cycle after each hit keep chained PC hits three cycles apart
   task automatic exec(input logic [31:0] p);
      @(negedge clk);
      ev = 1'h1;
      pc = p;
      @(negedge clk);
      pc = 32'h4;
      @(negedge clk);
      ev = 1'h0;
   endtask
   task automatic run(input logic [31:0] q[4], input int nexp);
      int b;
      b = nbrk;
      foreach (q[i]) if (q[i] != 32'h0) exec(q[i]);
      tick(4);
      chk(85'(nbrk - b), 85'(nexp));
   endtask
   task automatic enable_seq();
      tick(18);
      i_emu.en(evtrc_pkg::CH1);
      i_emu.en(evtrc_pkg::CH2);
      i_emu.en(evtrc_pkg::CH3);
      i_emu.en(evtrc_pkg::CHRP);
   endtask
   task automatic bus(input logic [31:0] a, input logic [1:0] k, input logic ib,
                      input logic [1:0] m, input logic keep, input logic [2:0] rk);
      logic [47:0] ts;
      @(negedge clk);
      bv = 1'h1;
      ba = a;
      bk = k;
      ibus = ib;
      mst = m;
      ts = tsn;
      @(negedge clk);
      bv = 1'h0;
      tick(2);
      if (keep) begin
         rda = wp;
         wp = wp + 8'h1;
         tick(2);
         chk(rdat, {ts, rk, m, a});
      end
      chk(85'(wptr), 85'(wp));
   endtask
   task automatic t_reset();
      logic [47:0] a;
      chk(85'(tsn), 85'h0);
      chk(85'(chen), 85'h0);
      a = tsn;
      tick(10);
      chk(85'(tsn), 85'(srst ? a : a + 48'ha));
   endtask
   task automatic t_seq();
      int n;
      i_emu.cfg(evtrc_pkg::CH3, 32'h1068, evtrc_pkg::KIND_PC_AFTER);
      i_emu.cfg(evtrc_pkg::CH2, 32'h107a, evtrc_pkg::KIND_PC_AFTER);
      i_emu.cfg(evtrc_pkg::CH1, 32'h1086, evtrc_pkg::KIND_PC_AFTER);
      i_emu.cfg(evtrc_pkg::CHRP, 32'h2000, evtrc_pkg::KIND_PC_AFTER);
      enable_seq();
      i_emu.combo(evtrc_pkg::SEQ_BRK, 1'h1, 8'h1);
      n = int'(hold === 1'h1);
      repeat (24) begin
         @(negedge clk);
         if (hold === 1'h1) n++;
      end
      chk(85'(n), 85'(evtrc_pkg::UPD_HOLD_CYC));
      chk(85'(chen), 85'h0);
      enable_seq();
      chk(85'(chen), 85'h27);
      run('{32'h1086, 32'h107a, 32'h1068, 32'h2000}, 0);
      run('{32'h1068, 32'h107a, 32'h2000, 32'h1086}, 0);
      run('{32'h1068, 32'h107a, 32'h1086, 32'h0}, 1);
      i_emu.combo(evtrc_pkg::SEQ_BRK, 1'h0, 8'h2);
      enable_seq();
      run('{32'h1068, 32'h107a, 32'h1086, 32'h0}, 0);
      run('{32'h1068, 32'h107a, 32'h1086, 32'h0}, 1);
      i_emu.combo(evtrc_pkg::SEQ_BRK, 1'h0, 8'h1);
      enable_seq();
      i_emu.cfg(evtrc_pkg::CH5, 32'h3000, evtrc_pkg::KIND_PC_AFTER);
      run('{32'h1068, 32'h107a, 32'h1086, 32'h0}, 0);
      tick(12);
      por = 1'h1;
      run('{32'h1068, 32'h107a, 32'h1086, 32'h0}, 0);
      por = 1'h0;
      run('{32'h1068, 32'h107a, 32'h1086, 32'h0}, 1);
   endtask
   task automatic t_trace();
      int b;
      i_emu.combo(evtrc_pkg::SEQ_NONE, 1'h0, 8'h1);
      i_emu.cfg(evtrc_pkg::CH1, 32'h300, evtrc_pkg::KIND_DATA);
      tick(18);
      i_emu.en(evtrc_pkg::CH1);
      ttype = evtrc_pkg::TT_MBUS;
      acq = 9'h11;
      bus(32'h100, evtrc_pkg::BUS_RD, 1'h0, evtrc_pkg::MST_CPU, 1'h1, evtrc_pkg::REC_READ);
      bus(32'h104, evtrc_pkg::BUS_WR, 1'h0, evtrc_pkg::MST_CPU, 1'h0, 3'h0);
      bus(32'h108, evtrc_pkg::BUS_FETCH, 1'h0, evtrc_pkg::MST_CPU, 1'h0, 3'h0);
      ttype = evtrc_pkg::TT_IBUS;
      acq = 9'hb1;
      bus(32'h200, evtrc_pkg::BUS_RD, 1'h1, evtrc_pkg::MST_DMA, 1'h1, evtrc_pkg::REC_READ);
      bus(32'h204, evtrc_pkg::BUS_RD, 1'h1, evtrc_pkg::MST_CPU, 1'h0, 3'h0);
      bus(32'h208, evtrc_pkg::BUS_FETCH, 1'h1, evtrc_pkg::MST_DMA, 1'h1, evtrc_pkg::REC_FETCH);
      bus(32'h20c, evtrc_pkg::BUS_RD, 1'h0, evtrc_pkg::MST_CPU, 1'h0, 3'h0);
      ttype = evtrc_pkg::TT_MBUS;
      acq = 9'h11;
      cond = 1'h1;
      bus(32'h300, evtrc_pkg::BUS_RD, 1'h0, evtrc_pkg::MST_CPU, 1'h1, evtrc_pkg::REC_READ);
      bus(32'h304, evtrc_pkg::BUS_RD, 1'h0, evtrc_pkg::MST_CPU, 1'h0, 3'h0);
      cond = 1'h0;
      halt = 1'h1;
      b = nbrk;
      bus(32'h304, evtrc_pkg::BUS_RD, 1'h0, evtrc_pkg::MST_CPU, 1'h1, evtrc_pkg::REC_READ);
      @(negedge clk);
      bv = 1'h1;
      ba = 32'h300;
      @(negedge clk);
      bv = 1'h0;
      tick(2);
      chk(85'(stopped), 85'h1);
      wp = wptr;
      bus(32'h308, evtrc_pkg::BUS_RD, 1'h0, evtrc_pkg::MST_CPU, 1'h0, 3'h0);
      chk(85'(nbrk - b), 85'h0);
      halt = 1'h0;
   endtask
   task automatic t_branch();
      logic [47:0] ts;
      @(negedge clk);
      restart = 1'h1;
      br = 1'h1;
      bra = 32'h500;
      acq = 9'h19;
      @(negedge clk);
      restart = 1'h0;
      br = 1'h0;
      chk(85'(stopped), 85'h0);
      @(negedge clk);
      bv = 1'h1;
      ba = 32'h504;
      ts = tsn;
      @(negedge clk);
      bv = 1'h0;
      rda = wp;
      tick(2);
      chk(rdat, {ts, evtrc_pkg::REC_BRANCH, evtrc_pkg::MST_CPU, 32'h500});
      rda = wp + 8'h1;
      tick(2);
      chk(rdat, {ts, evtrc_pkg::REC_READ, evtrc_pkg::MST_CPU, 32'h504});
      wp = wp + 8'h2;
      chk(85'(wptr), 85'(wp));
   endtask
   task automatic t_win();
      i_emu.combo(evtrc_pkg::SEQ_NONE, 1'h0, 8'h1, 1'h1);
      i_emu.cfg(evtrc_pkg::CH5, 32'h600, evtrc_pkg::KIND_FETCH);
      i_emu.cfg(evtrc_pkg::CH4, 32'h700, evtrc_pkg::KIND_FETCH);
      tick(18);
      i_emu.en(evtrc_pkg::CH4);
      i_emu.en(evtrc_pkg::CH5);
      bus(32'h604, evtrc_pkg::BUS_RD, 1'h0, evtrc_pkg::MST_CPU, 1'h0, 3'h0);
      bus(32'h600, evtrc_pkg::BUS_FETCH, 1'h0, evtrc_pkg::MST_CPU, 1'h0, 3'h0);
      chk(85'(win), 85'h1);
      cond = 1'h1;
      bus(32'h300, evtrc_pkg::BUS_RD, 1'h0, evtrc_pkg::MST_CPU, 1'h1, evtrc_pkg::REC_READ);
      bus(32'h604, evtrc_pkg::BUS_RD, 1'h0, evtrc_pkg::MST_CPU, 1'h0, 3'h0);
      bus(32'h700, evtrc_pkg::BUS_FETCH, 1'h0, evtrc_pkg::MST_CPU, 1'h0, 3'h0);
      chk(85'(win), 85'h0);
      bus(32'h300, evtrc_pkg::BUS_RD, 1'h0, evtrc_pkg::MST_CPU, 1'h0, 3'h0);
      cond = 1'h0;
      bus(32'h600, evtrc_pkg::BUS_FETCH, 1'h0, evtrc_pkg::MST_CPU, 1'h0, 3'h0);
      chk(85'(win), 85'h1);
      @(negedge clk);
      ovr = 1'h1;
      @(negedge clk);
      ovr = 1'h0;
      chk(85'(win), 85'h0);
   endtask
   task automatic t_tstop();
      i_emu.combo(evtrc_pkg::SEQ_TSTOP, 1'h0, 8'h1);
      i_emu.cfg(evtrc_pkg::CH1, 32'h1086, evtrc_pkg::KIND_PC_AFTER);
      enable_seq();
      run('{32'h1068, 32'h107a, 32'h1086, 32'h0}, 0);
      chk(85'(stopped), 85'h1);
   endtask
   initial begin
      #(25 * 5000);
      n_mismatch++;
      end_sim();
   end
   initial begin
      tick(5);
      t_reset();
      srst = 1'h0;
      t_reset();
      t_seq();
      t_trace();
      t_branch();
      t_win();
      t_tstop();
      end_sim();
   end
endmodule
